// *** fspl_pkg.sv ***
// shared constants, types and layouts for the flash status and protection logic
`default_nettype none
package fspl_pkg;

   // array geometry
   localparam int ADDR_W      = 23;
   typedef logic [ADDR_W-1:0] fspl_addr_t;
   localparam fspl_addr_t ARRAY_LAST    = 23'h7f_ffff;
   localparam fspl_addr_t ADDR_ZERO     = 23'h00_0000;
   localparam fspl_addr_t SECTOR_BYTES     = 23'h00_1000;
   localparam fspl_addr_t BLK_BYTES        = 23'h01_0000;
   localparam fspl_addr_t SECTOR_MAX_BYTES = 23'h00_8000;
   localparam int SECTOR_SIZE = 4096;
   localparam int BLOCK_SIZE  = 65536;
   localparam int END_SECTORS = 16;
   localparam int MID_BLOCKS  = 126;
   localparam int LOCK_N      = 2 * END_SECTORS + MID_BLOCKS;

   // protect-level codes
   localparam logic [2:0] BP_NONE      = 3'h0;
   localparam logic [2:0] BP_ALL       = 3'h7;
   localparam logic [2:0] BP_SECTOR_STEPS = 3'h3;
   localparam logic [2:0] BP_ONE       = 3'h1;

   // instruction codes; status access codes are free defaults
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_RESUME  = 8'h7a;
   localparam logic [7:0] OP_RD_SR2  = 8'h35;
   localparam logic [7:0] OP_RD_SR3  = 8'h15;
   localparam logic [7:0] OP_WR_SR2  = 8'h31;
   localparam logic [7:0] OP_WR_SR3  = 8'h11;

   // second status byte (S8..S15) and third (S16..S23) field positions
   localparam int SR2_QUAD     = 1;
   localparam int SR2_LOCK_LO  = 3;
   localparam int SR2_INVERT   = 6;
   localparam int SR2_SUSPEND  = 7;
   localparam int SR3_SCHEME   = 2;
   localparam int SR3_DRIVE_LO = 5;
   localparam int SR3_DRIVE_HI = 6;
   localparam logic [7:0] SR2_CFG_MASK  = 8'h42;
   localparam logic [7:0] SR2_LOCK_MASK = 8'h38;
   localparam logic [7:0] SR3_CFG_MASK  = 8'h64;
   localparam logic [7:0] SR_RESET      = 8'h00;

   // serial frame bookkeeping
   localparam int FRAME_W = 5;
   localparam logic [FRAME_W-1:0] FRAME_ONE = 5'h01;
   localparam logic [FRAME_W-1:0] FRAME_OP_LAST = 5'h07;
   localparam logic [FRAME_W-1:0] FRAME_CMD = 5'h08;
   localparam logic [FRAME_W-1:0] FRAME_WR  = 5'h10;
   localparam logic [FRAME_W-1:0] FRAME_SAT = 5'h1f;

   // read drive strength in percent
   localparam logic [6:0] DRV_PCT_100 = 7'h64;
   localparam logic [6:0] DRV_PCT_75  = 7'h4b;
   localparam logic [6:0] DRV_PCT_50  = 7'h32;
   localparam logic [6:0] DRV_PCT_25  = 7'h19;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_FRAME  = 3'b010,
      ST_COMMIT = 3'b100
   } fspl_state_e;

   // block-protect fields held by the first status byte
   typedef struct packed {
      logic       sector_granularity;
      logic       top_bottom_sel;
      logic [2:0] prot_level;
   } fspl_prot_s;

   // erase/program permission request
   typedef struct packed {
      logic       valid;
      logic       secreg;
      logic [1:0] secreg_idx;
      fspl_addr_t first;
      fspl_addr_t last;
   } fspl_pe_s;

   typedef struct packed {
      logic       none;
      fspl_addr_t lo;
      fspl_addr_t hi;
   } fspl_range_s;

endpackage : fspl_pkg
`default_nettype wire

// *** fspl_status_prot.sv ***
// status bytes two and three, serial status access and write-protect decode
//
// What this block does
// - suspend instruction sets suspend flag, read-only
// - resume instruction or power cycle clears suspend
// - security lock bits default zero, unlocked
// - each lock bit settable alone by write
// - set lock holds until reset; locked register refuses
// - quad off: hold active, single/dual only
// - quad on: data lines, no hold, quad
// - scheme zero uses invert/sector/top/level bits
// - scheme one uses per-block lock bits
// - all block locks set after reset
// - drive field selects 100/75/50/25 percent
// - reserved bits read zero, writes ignored
// - top blocks protected, doubling from 128KB
// - bottom blocks protected, doubling from 128KB
// - level 000 none, 111 whole array
// - sector mode top: 4/8/16/32KB
// - sector mode bottom: 4/8/16/32KB
// - request touching protected area is ignored
// - invert bit complements the protected set
// - lock zero allows, lock one refuses
`timescale 1ns/1ns
`default_nettype none
module fspl_status_prot #(
   parameter logic QUAD_RESET = 1'b0
) (
   input  wire logic                   mclk,
   input  wire logic                   rst,
   input  wire logic                   ce,
   input  wire logic                   sclk,
   input  wire logic                   cs_n,
   input  wire logic                   sdi,
   output logic                        sdo,
   output logic                        sdo_oe,
   input  wire fspl_pkg::fspl_prot_s   prot,
   input  wire logic                   sr_write_ok,
   input  wire logic [2:0]             otp_lock_init,
   input  wire logic                   lock_wr,
   input  wire logic                   lock_set,
   input  wire logic [7:0]             lock_idx,
   input  wire fspl_pkg::fspl_pe_s     pe,
   output logic                        pe_grant,
   output logic                        pe_deny,
   output logic                        suspend_flag,
   output logic                        quad_io_enable,
   output logic                        hold_func_en,
   output logic                        protect_scheme_sel,
   output logic [6:0]                  drive_pct,
   output logic [2:0]                  secreg_lock
);

   // ---------------- link side, on the serial clock ----------------
   logic                         first_reg;
   logic [fspl_pkg::FRAME_W-1:0] bits_reg;
   logic [15:0]                  shift_reg;
   logic [7:0]                   op_reg;
   logic                         sdo_reg;
   logic                         oe_reg;
   logic [7:0]                   sr2_reg;
   logic [7:0]                   sr3_reg;

   // frame start is flagged by chip select alone; the counters restart at the first edge,
   // so the finished frame stays readable after chip select rises
   always_ff @(posedge sclk or posedge cs_n)
   begin
      if (cs_n)
         first_reg <= 1'b1;
      else
         first_reg <= 1'b0;
   end

   wire [fspl_pkg::FRAME_W-1:0] bits_next = first_reg ? fspl_pkg::FRAME_ONE :
      (bits_reg == fspl_pkg::FRAME_SAT) ? bits_reg : bits_reg + fspl_pkg::FRAME_ONE;
   wire shift_en = first_reg || (bits_reg < fspl_pkg::FRAME_WR);
   wire op_done  = !first_reg && (bits_reg == fspl_pkg::FRAME_OP_LAST);

   always_ff @(posedge sclk)
   begin
      bits_reg <= bits_next;
      if (shift_en)
         shift_reg <= {shift_reg[14:0], sdi};
      if (op_done)
         op_reg <= {shift_reg[6:0], sdi};
   end

   // status bytes are only written while no frame runs, so they are steady here
   wire       rd_sr2  = op_reg == fspl_pkg::OP_RD_SR2;
   wire       rd_sr3  = op_reg == fspl_pkg::OP_RD_SR3;
   wire [7:0] rd_byte = rd_sr3 ? sr3_reg : sr2_reg;
   wire       rd_live = !first_reg && (bits_reg >= fspl_pkg::FRAME_CMD) && (rd_sr2 || rd_sr3);

   always_ff @(negedge sclk)
   begin
      sdo_reg <= rd_byte[~bits_reg[2:0]];
   end

   always_ff @(negedge sclk or posedge cs_n)
   begin
      if (cs_n)
         oe_reg <= 1'b0;
      else
         oe_reg <= rd_live;
   end

   assign sdo    = sdo_reg;
   assign sdo_oe = oe_reg && !cs_n;

   // ---------------- core side, on mclk ----------------
   logic                  cs_s1_reg;
   logic                  cs_s2_reg;
   logic                  strap_reg;
   fspl_pkg::fspl_state_e state_reg;
   fspl_pkg::fspl_state_e state_next;
   logic [7:0]            sr2_next;
   logic [7:0]            sr3_next;
   logic [fspl_pkg::LOCK_N-1:0] lock_reg;
   logic [fspl_pkg::LOCK_N-1:0] lock_next;
   logic                  grant_reg;
   logic                  deny_reg;
   // decoded below, declared here because the answer flops read it
   logic                  pe_block;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         cs_s1_reg <= 1'b1;
         cs_s2_reg <= 1'b1;
      end
      else if (ce)
      begin
         cs_s1_reg <= cs_n;
         cs_s2_reg <= cs_s1_reg;
      end
   end

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         fspl_pkg::ST_IDLE:   if (!cs_s2_reg) state_next = fspl_pkg::ST_FRAME;
         fspl_pkg::ST_FRAME:  if (cs_s2_reg) state_next = fspl_pkg::ST_COMMIT;
         fspl_pkg::ST_COMMIT: state_next = fspl_pkg::ST_IDLE;
         default:             state_next = fspl_pkg::ST_IDLE;
      endcase
   end

   // a frame counts only if it ended on exactly one or two whole bytes
   wire commit   = state_reg == fspl_pkg::ST_COMMIT;
   wire len_cmd  = bits_reg == fspl_pkg::FRAME_CMD;
   wire len_wr   = bits_reg == fspl_pkg::FRAME_WR;
   wire do_susp  = commit && len_cmd && (op_reg == fspl_pkg::OP_SUSPEND);
   wire do_resm  = commit && len_cmd && (op_reg == fspl_pkg::OP_RESUME);
   wire do_wr2   = commit && len_wr && sr_write_ok && (op_reg == fspl_pkg::OP_WR_SR2);
   wire do_wr3   = commit && len_wr && sr_write_ok && (op_reg == fspl_pkg::OP_WR_SR3);
   wire [7:0] wr_data = shift_reg[7:0];

   // reserved positions never take a written value and read back zero
   wire [7:0] sr2_cfg  = do_wr2 ? (wr_data & fspl_pkg::SR2_CFG_MASK)
                                : (sr2_reg & fspl_pkg::SR2_CFG_MASK);
   wire [7:0] lock_or  = (do_wr2 ? (wr_data & fspl_pkg::SR2_LOCK_MASK) : fspl_pkg::SR_RESET)
                       | (strap_reg ? ({5'h00, otp_lock_init} << fspl_pkg::SR2_LOCK_LO) : fspl_pkg::SR_RESET);
   wire [7:0] sr2_lock = (sr2_reg & fspl_pkg::SR2_LOCK_MASK) | lock_or;
   wire       sus_next = do_susp ? 1'b1 :
                         do_resm ? 1'b0 : sr2_reg[fspl_pkg::SR2_SUSPEND];

   always_comb
   begin
      sr2_next = sr2_cfg | sr2_lock;
      sr2_next[fspl_pkg::SR2_SUSPEND] = sus_next;
      sr3_next = do_wr3 ? (wr_data & fspl_pkg::SR3_CFG_MASK) : sr3_reg;
   end

   // per-block/per-sector lock write port from the instruction layer
   always_comb
   begin
      lock_next = lock_reg;
      if (lock_wr && (lock_idx < 8'(fspl_pkg::LOCK_N)))
         lock_next[lock_idx] = lock_set;
   end

   // otp lock image is loaded one cycle after reset release, never under reset
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state_reg <= fspl_pkg::ST_IDLE;
         sr2_reg   <= QUAD_RESET ? fspl_pkg::SR2_CFG_MASK & (8'h01 << fspl_pkg::SR2_QUAD)
                               : fspl_pkg::SR_RESET;
         sr3_reg   <= fspl_pkg::SR_RESET;
         strap_reg <= 1'b1;
         lock_reg  <= '1;
         grant_reg <= 1'b0;
         deny_reg  <= 1'b0;
      end
      else if (ce)
      begin
         state_reg <= state_next;
         sr2_reg   <= sr2_next;
         sr3_reg   <= sr3_next;
         strap_reg <= 1'b0;
         lock_reg  <= lock_next;
         grant_reg <= pe.valid && !pe_block;
         deny_reg  <= pe.valid && pe_block;
      end
   end

   // ---------------- configuration outputs ----------------
   wire [1:0] drv = {sr3_reg[fspl_pkg::SR3_DRIVE_HI], sr3_reg[fspl_pkg::SR3_DRIVE_LO]};

   assign suspend_flag       = sr2_reg[fspl_pkg::SR2_SUSPEND];
   assign quad_io_enable     = sr2_reg[fspl_pkg::SR2_QUAD];
   assign hold_func_en       = !sr2_reg[fspl_pkg::SR2_QUAD];
   assign protect_scheme_sel = sr3_reg[fspl_pkg::SR3_SCHEME];
   assign secreg_lock        = sr2_reg[fspl_pkg::SR2_LOCK_LO +: 3];
   assign drive_pct = (drv == 2'b00) ? fspl_pkg::DRV_PCT_100 :
                      (drv == 2'b01) ? fspl_pkg::DRV_PCT_75  :
                      (drv == 2'b10) ? fspl_pkg::DRV_PCT_50  : fspl_pkg::DRV_PCT_25;
   assign pe_grant = grant_reg;
   assign pe_deny  = deny_reg;

   // ---------------- protection decode ----------------
   function automatic logic overlaps(input fspl_pkg::fspl_addr_t f, input fspl_pkg::fspl_addr_t l,
                                     input fspl_pkg::fspl_addr_t lo, input fspl_pkg::fspl_addr_t hi);
      overlaps = !((l < lo) || (f > hi));
   endfunction : overlaps

   function automatic fspl_pkg::fspl_range_s level_range(input fspl_pkg::fspl_prot_s p);
      fspl_pkg::fspl_addr_t size;
      level_range.none = (p.prot_level == fspl_pkg::BP_NONE);
      if (p.sector_granularity)
         size = (p.prot_level > fspl_pkg::BP_SECTOR_STEPS) ? fspl_pkg::SECTOR_MAX_BYTES
              : fspl_pkg::SECTOR_BYTES << (p.prot_level - fspl_pkg::BP_ONE);
      else
         size = fspl_pkg::BLK_BYTES << p.prot_level;
      if (p.prot_level == fspl_pkg::BP_ALL)
      begin
         level_range.lo = fspl_pkg::ADDR_ZERO;
         level_range.hi = fspl_pkg::ARRAY_LAST;
      end
      else if (p.top_bottom_sel)
      begin
         level_range.lo = fspl_pkg::ADDR_ZERO;
         level_range.hi = size - fspl_pkg::BP_ONE;
      end
      else
      begin
         level_range.lo = fspl_pkg::ARRAY_LAST - size + fspl_pkg::BP_ONE;
         level_range.hi = fspl_pkg::ARRAY_LAST;
      end
   endfunction : level_range

   function automatic fspl_pkg::fspl_addr_t unit_lo(input int i);
      int a;
      if (i < fspl_pkg::END_SECTORS)
         a = i * fspl_pkg::SECTOR_SIZE;
      else if (i < fspl_pkg::END_SECTORS + fspl_pkg::MID_BLOCKS)
         a = (i - fspl_pkg::END_SECTORS + 1) * fspl_pkg::BLOCK_SIZE;
      else
         a = (fspl_pkg::MID_BLOCKS + 1) * fspl_pkg::BLOCK_SIZE
           + (i - fspl_pkg::END_SECTORS - fspl_pkg::MID_BLOCKS) * fspl_pkg::SECTOR_SIZE;
      unit_lo = fspl_pkg::fspl_addr_t'(a);
   endfunction : unit_lo

   function automatic fspl_pkg::fspl_addr_t unit_hi(input int i);
      int s;
      s = ((i < fspl_pkg::END_SECTORS) || (i >= fspl_pkg::END_SECTORS + fspl_pkg::MID_BLOCKS))
        ? fspl_pkg::SECTOR_SIZE : fspl_pkg::BLOCK_SIZE;
      unit_hi = unit_lo(i) + fspl_pkg::fspl_addr_t'(s - 1);
   endfunction : unit_hi

   // units: 16 bottom sectors, 126 middle blocks, 16 top sectors
   logic [fspl_pkg::LOCK_N-1:0] unit_hit;
   genvar gi;
   generate
      for (gi = 0; gi < fspl_pkg::LOCK_N; gi++)
      begin : g_unit
         assign unit_hit[gi] = overlaps(pe.first, pe.last, unit_lo(gi), unit_hi(gi));
      end
   endgenerate

   wire fspl_pkg::fspl_range_s rng = level_range(prot);
   wire invert_on = sr2_reg[fspl_pkg::SR2_INVERT];
   wire in_rng   = !rng.none && (pe.first >= rng.lo) && (pe.last <= rng.hi);
   // complement: only requests lying wholly inside the chosen set may proceed
   wire bp_block = invert_on ? !in_rng
                       : (!rng.none && overlaps(pe.first, pe.last, rng.lo, rng.hi));
   wire lk_block = |(lock_reg & unit_hit);
   wire sr_block = (pe.secreg_idx == 2'b00) || secreg_lock[pe.secreg_idx - 2'b01];
   assign pe_block = pe.secreg ? sr_block :
                     (protect_scheme_sel ? lk_block : bp_block);

   // ---------------- checks ----------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   suspend_set_a: assert property (ce && do_susp |=> suspend_flag)
      else $error("suspend flag not set by suspend");
   suspend_clr_a: assert property (ce && do_resm |=> !suspend_flag ##1 !suspend_flag || do_susp)
      else $error("suspend flag not cleared by resume");
   lock_reset_a: assert property (disable iff (1'b0) rst |=> secreg_lock == 3'b000)
      else $error("security locks not zero after reset");
   lock_single_a: assert property (ce && do_wr2 && !strap_reg |=>
      secreg_lock == ($past(secreg_lock) | $past(wr_data[fspl_pkg::SR2_LOCK_LO +: 3])))
      else $error("lock write disturbed other lock bits");
   lock_sticky_a: assert property ((secreg_lock & $past(secreg_lock)) == $past(secreg_lock))
      else $error("security lock bit returned to zero");
   quad_pins_a: assert property (ce && do_wr2 |=>
      quad_io_enable == $past(wr_data[fspl_pkg::SR2_QUAD]) && hold_func_en != quad_io_enable)
      else $error("quad enable or hold function wrong after write");
   block_reset_a: assert property (disable iff (1'b0) rst |=> &lock_reg)
      else $error("block locks not all set after reset");
   level_all_a: assert property (ce && pe.valid && !pe.secreg && !protect_scheme_sel && !invert_on
      && prot.prot_level == fspl_pkg::BP_ALL |=> pe_deny && !pe_grant)
      else $error("whole-array protection let a request through");
   level_none_a: assert property (ce && pe.valid && !pe.secreg && !protect_scheme_sel && !invert_on
      && prot.prot_level == fspl_pkg::BP_NONE |=> pe_grant && !pe_deny)
      else $error("no-protection level refused a request");
   top_blocks_a: assert property (ce && pe.valid && !pe.secreg && !protect_scheme_sel && !invert_on
      && prot == 5'b00001 && pe.last < 23'h7e_0000 |=> pe_grant)
      else $error("request below top 128KB refused");
   bottom_blocks_a: assert property (ce && pe.valid && !pe.secreg && !protect_scheme_sel
      && !invert_on && prot == 5'b01001 && pe.first > 23'h01_ffff |=> pe_grant)
      else $error("request above bottom 128KB refused");
   lock_port_a: assert property (ce && lock_wr && lock_idx < 8'(fspl_pkg::LOCK_N) |=>
      lock_reg[$past(lock_idx)] == $past(lock_set))
      else $error("block lock write not taken");
   drive_half_a: assert property (drv == 2'b10 |-> drive_pct == fspl_pkg::DRV_PCT_50)
      else $error("drive code 10 not half strength");
   lock_refuse_a: assert property (ce && pe.valid && !pe.secreg && protect_scheme_sel && lock_reg[0]
      && pe.first == fspl_pkg::ADDR_ZERO |=> pe_deny)
      else $error("locked bottom sector accepted a request");

   suspend_resume_c: cover property (do_susp ##[1:200] do_resm);
   status_write_c:   cover property (ce && do_wr2 ##[1:200] ce && do_wr3);
   invert_deny_c:    cover property (ce && pe.valid && invert_on && !protect_scheme_sel ##1 pe_deny);
   lock_grant_c:     cover property (ce && pe.valid && protect_scheme_sel ##1 pe_grant);
   quad_on_c:        cover property (ce && do_wr2 ##1 quad_io_enable);

endmodule : fspl_status_prot
`default_nettype wire

// *** fspl_host.sv ***
// host-side serial controller model for the status link
`timescale 1ns/1ns
`default_nettype none
module fspl_host (
   output logic       sclk,
   output logic       cs_n,
   output logic       sdi,
   input  wire logic  sdo,
   input  wire logic  sdo_oe,
   output logic [7:0] rd_byte,
   output logic       rd_stb
);
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b0;
      sdi = 1'b0;
      rd_byte = 8'h00;
      rd_stb = 1'b0;
      // a clean rising chip select arms the frame-start flag before the first frame
      #1 cs_n = 1'b1;
   end

   // sclk runs only inside a frame, 12 ns period, stands low between frames
   task automatic xfer(input logic [15:0] bits, input int n, input logic is_rd);
      cs_n = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         sdi = bits[15-i];
         #6 sclk = 1'b1;
         if (i >= 8)
            rd_byte[15-i] = sdo_oe ? sdo : ~sdo;
         #6 sclk = 1'b0;
      end
      #6 cs_n = 1'b1;
      // released line shows the inverse so a stale bit cannot pass for data
      sdi = ~sdi;
      if (is_rd)
      begin
         rd_stb = 1'b1;
         #1 rd_stb = 1'b0;
      end
   endtask : xfer
endmodule : fspl_host
`default_nettype wire

// *** fspl_status_prot_test.sv ***
// self-checking bench for the flash status and protection logic
`timescale 1ns/1ns
`default_nettype none
module fspl_status_prot_test;
   logic                 mclk, rst, ce, sr_write_ok, lock_wr, lock_set;
   logic [2:0]           otp_lock_init;
   logic [7:0]           lock_idx;
   fspl_pkg::fspl_prot_s prot;
   fspl_pkg::fspl_pe_s   pe;
   logic                 sclk, cs_n, sdi, sdo, sdo_oe, pe_grant, pe_deny, rd_stb;
   logic                 suspend_flag, quad_io_enable, hold_func_en, protect_scheme_sel;
   logic [6:0]           drive_pct;
   logic [2:0]           secreg_lock;
   logic [7:0]           rd_byte;
   logic [22:0]          sz, r;
   int                   fails = 0;
   int                   n_tests = 0;
   logic                 pe_q[$];
   logic [7:0]           rd_q[$];
   wire logic [7:0]      lv = {suspend_flag, quad_io_enable, hold_func_en, protect_scheme_sel, 1'b0, secreg_lock};
   localparam logic [28:0] TAB [17] = '{
      {5'h00, 23'h7f_ffff, 1'b1}, {5'h18, 23'h00_0000, 1'b1}, {5'h07, 23'h00_0000, 1'b0},
      {5'h1f, 23'h40_0000, 1'b0}, {5'h11, 23'h7f_f000, 1'b0}, {5'h11, 23'h7f_efff, 1'b1},
      {5'h12, 23'h7f_e000, 1'b0}, {5'h13, 23'h7f_c000, 1'b0}, {5'h13, 23'h7f_bfff, 1'b1},
      {5'h15, 23'h7f_8000, 1'b0}, {5'h14, 23'h7f_7fff, 1'b1}, {5'h19, 23'h00_0fff, 1'b0},
      {5'h19, 23'h00_1000, 1'b1}, {5'h1a, 23'h00_1fff, 1'b0}, {5'h1b, 23'h00_3fff, 1'b0},
      {5'h1c, 23'h00_7fff, 1'b0}, {5'h15, 23'h00_8000, 1'b1}};

   fspl_status_prot dut (.mclk(mclk), .rst(rst), .ce(ce), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
      .sdo_oe(sdo_oe), .prot(prot), .sr_write_ok(sr_write_ok), .otp_lock_init(otp_lock_init),
      .lock_wr(lock_wr), .lock_set(lock_set), .lock_idx(lock_idx), .pe(pe), .pe_grant(pe_grant),
      .pe_deny(pe_deny), .suspend_flag(suspend_flag), .quad_io_enable(quad_io_enable),
      .hold_func_en(hold_func_en), .protect_scheme_sel(protect_scheme_sel), .drive_pct(drive_pct),
      .secreg_lock(secreg_lock));
   fspl_host host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
      .rd_byte(rd_byte), .rd_stb(rd_stb));

   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task automatic end_of_test();
      if (fails == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test

   task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_val

   task automatic cmp_pe(input logic g, input logic d, input logic e);
      n_tests++;
      if (g !== e || d !== !e)
      begin
         fails++;
         $display("wrong value at %0t: grant %b deny %b expected grant %b", $time, g, d, e);
      end
   endtask : cmp_pe

   // watchers take the oldest note whenever a result shows up
   always @(negedge mclk)
      if (pe_grant !== 1'b0 || pe_deny !== 1'b0)
      begin
         if (pe_q.size() == 0)
            cmp_pe(pe_grant, pe_deny, 1'bx);
         else
            cmp_pe(pe_grant, pe_deny, pe_q.pop_front());
      end
   always @(posedge rd_stb)
      cmp_val(rd_byte, (rd_q.size() == 0) ? 8'hxx : rd_q.pop_front());

   // frames start at an arbitrary phase of mclk; gap covers the commit delay
   task automatic frame(input logic [15:0] b, input int n, input logic is_rd);
      #($urandom % 50);
      host.xfer(b, n, is_rd);
      repeat (7) @(negedge mclk);
   endtask : frame
   task automatic wr(input logic [7:0] op, input logic [7:0] d, input logic [7:0] exp_lv);
      frame({op, d}, 16, 1'b0);
      cmp_val(lv, exp_lv);
   endtask : wr
   task automatic rd(input logic [7:0] op, input logic [7:0] exp);
      rd_q.push_back(exp);
      frame({op, 8'h00}, 16, 1'b1);
   endtask : rd
   // request stays valid so calls in a row run back to back
   task automatic req(input logic [4:0] p, input logic [2:0] s, input logic [22:0] a, b, input logic e);
      @(negedge mclk);
      prot = p;
      pe = {1'b1, s, a, b};
      pe_q.push_back(e);
   endtask : req
   task automatic idle();
      @(negedge mclk);
      pe.valid = 1'b0;
      repeat (2) @(negedge mclk);
   endtask : idle
   task automatic unlock(input logic [7:0] i);
      @(negedge mclk);
      {lock_wr, lock_set, lock_idx} = {2'b10, i};
      @(negedge mclk);
      lock_wr = 1'b0;
   endtask : unlock
   task automatic do_reset();
      rst = 1'b1;
      repeat (10) @(negedge mclk);
      rst = 1'b0;
      repeat (2) @(negedge mclk);
   endtask : do_reset

   initial
   begin
      #1_000_000;
      fails++;
      end_of_test();
   end

   initial
   begin
      {rst, ce, sr_write_ok, lock_wr, lock_set, lock_idx, otp_lock_init} = {3'b111, 13'h0000};
      prot = 5'h00;
      pe = '0;
      void'($urandom(32'hbf32));
      do_reset();
      cmp_val(lv, 8'h20);
      rd(fspl_pkg::OP_RD_SR2, 8'h00);
      for (int k = 1; k <= 6; k++)
      begin
         sz = 23'h02_0000 << (k - 1);
         r = 23'($urandom % sz);
         req({2'b00, 3'(k)}, 3'h0, 23'h7f_ffff - r, 23'h7f_ffff - r, 1'b0);
         req({2'b00, 3'(k)}, 3'h0, 23'h7f_ffff - sz - r, 23'h7f_ffff - sz, 1'b1);
         req({2'b00, 3'(k)}, 3'h0, 23'h7f_ffff - sz, 23'h7f_ffff - sz + 23'h00_0001, 1'b0);
         req({2'b01, 3'(k)}, 3'h0, r, r, 1'b0);
         req({2'b01, 3'(k)}, 3'h0, sz, sz + r, 1'b1);
         req({2'b01, 3'(k)}, 3'h0, sz - 23'h00_0001, sz, 1'b0);
      end
      foreach (TAB[i])
         req(TAB[i][28:24], 3'h0, TAB[i][23:1], TAB[i][23:1], TAB[i][0]);
      idle();
      {ce, pe.valid} = 2'b01;
      @(negedge mclk);
      {ce, pe.valid} = 2'b10;
      wr(fspl_pkg::OP_WR_SR2, 8'h40, 8'h20);
      req(5'h01, 3'h0, 23'h00_0000, 23'h00_0000, 1'b0);
      req(5'h01, 3'h0, 23'h7e_0000, 23'h7f_ffff, 1'b1);
      idle();
      wr(fspl_pkg::OP_WR_SR2, 8'h00, 8'h20);
      frame({fspl_pkg::OP_SUSPEND, 8'h00}, 8, 1'b0);
      cmp_val(lv, 8'ha0);
      rd(fspl_pkg::OP_RD_SR2, 8'h80);
      wr(fspl_pkg::OP_WR_SR2, 8'h00, 8'ha0);
      frame({fspl_pkg::OP_RESUME, 8'h00}, 8, 1'b0);
      cmp_val(lv, 8'h20);
      sr_write_ok = 1'b0;
      wr(fspl_pkg::OP_WR_SR2, 8'h02, 8'h20);
      sr_write_ok = 1'b1;
      wr(fspl_pkg::OP_WR_SR2, 8'h08, 8'h21);
      req(5'h00, 3'h5, 23'h00_0000, 23'h00_0000, 1'b0);
      req(5'h00, 3'h6, 23'h00_0000, 23'h00_0000, 1'b1);
      idle();
      wr(fspl_pkg::OP_WR_SR2, 8'h10, 8'h23);
      wr(fspl_pkg::OP_WR_SR2, 8'h00, 8'h23);
      wr(fspl_pkg::OP_WR_SR2, 8'hff, 8'h47);
      rd(fspl_pkg::OP_RD_SR2, 8'h7a);
      wr(fspl_pkg::OP_WR_SR2, 8'h00, 8'h27);
      for (int d = 0; d < 4; d++)
      begin
         frame({fspl_pkg::OP_WR_SR3, 1'b0, 2'(d), 5'h00}, 16, 1'b0);
         cmp_val({1'b0, drive_pct}, (d == 0) ? 8'h64 : (d == 1) ? 8'h4b : (d == 2) ? 8'h32 : 8'h19);
      end
      rd(fspl_pkg::OP_RD_SR3, 8'h60);
      wr(fspl_pkg::OP_WR_SR3, 8'hff, 8'h37);
      rd(fspl_pkg::OP_RD_SR3, 8'h64);
      req(5'h00, 3'h0, 23'h00_0000, 23'h00_0000, 1'b0);
      idle();
      unlock(8'h00);
      unlock(8'h10);
      req(5'h07, 3'h0, 23'h00_0000, 23'h00_0fff, 1'b1);
      req(5'h07, 3'h0, 23'h00_0000, 23'h00_1fff, 1'b0);
      req(5'h07, 3'h0, 23'h01_0000, 23'h01_ffff, 1'b1);
      idle();
      frame({fspl_pkg::OP_SUSPEND, 8'h00}, 8, 1'b0);
      otp_lock_init = 3'b100;
      do_reset();
      cmp_val(lv, 8'h24);
      wr(fspl_pkg::OP_WR_SR3, 8'h04, 8'h34);
      req(5'h00, 3'h0, 23'h00_0000, 23'h00_0000, 1'b0);
      idle();
      end_of_test();
   end
endmodule : fspl_status_prot_test
`default_nettype wire
